// ===== hw/prm_pkg.sv
`default_nettype none

package prm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus and register map.
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 8;
  localparam logic [7:0]  RMP1_OFS    = 8'h01;
  localparam logic [7:0]  RMP2_OFS    = 8'h02;
  localparam logic [7:0]  RMP1_RST    = 8'h0c;
  localparam logic [7:0]  RMP2_RST    = 8'h00;
  localparam logic [7:0]  RD_UNMAPPED = 8'h00;

  // Field positions in remap_control_one.
  localparam int SP1_ALT_BIT  = 7;
  localparam int UCK_ALT_BIT  = 6;
  localparam int UTR_LO       = 4;
  localparam int TDMA_LO      = 2;
  localparam int ADMA_LO      = 0;
  localparam int SEL_W        = 2;

  // Field positions in remap_control_two.
  localparam int BRK_ALT_BIT  = 7;
  localparam int T3_FAR_BIT   = 6;
  localparam int SP2_ALT_BIT  = 5;
  localparam int T3_LSE_BIT   = 4;
  localparam int T2_LSE_BIT   = 3;
  localparam int T3_ALT_BIT   = 2;
  localparam int T2_ALT_BIT   = 1;
  localparam int ADCT_ALT_BIT = 0;

  // Transmit/receive placement codes of the serial port one.
  typedef enum logic [1:0] {
    UTR_PORTC    = 2'h0,
    UTR_PORTA    = 2'h1,
    UTR_PORTC_HI = 2'h2,
    UTR_RSVD     = 2'h3
  } prm_utr_t;

  ////////////////////////////////////////////////////////////////////////////
  // Pad indices; the oscillator input is an input-only pad.
  localparam int N_PAD   = 32;
  localparam int N_CH    = 4;
  localparam int SYNC_N  = 2;
  localparam int PAD_PA0 = 0;
  localparam int PAD_PA2 = 1;
  localparam int PAD_PA3 = 2;
  localparam int PAD_PA4 = 3;
  localparam int PAD_PA5 = 4;
  localparam int PAD_PA6 = 5;
  localparam int PAD_PB3 = 6;
  localparam int PAD_PB4 = 7;
  localparam int PAD_PB5 = 8;
  localparam int PAD_PB6 = 9;
  localparam int PAD_PB7 = 10;
  localparam int PAD_PC2 = 11;
  localparam int PAD_PC3 = 12;
  localparam int PAD_PC4 = 13;
  localparam int PAD_PC5 = 14;
  localparam int PAD_PC6 = 15;
  localparam int PAD_PD0 = 16;
  localparam int PAD_PD1 = 17;
  localparam int PAD_PG0 = 18;
  localparam int PAD_PG1 = 19;
  localparam int PAD_PG3 = 20;
  localparam int PAD_PG4 = 21;
  localparam int PAD_PG5 = 22;
  localparam int PAD_PG6 = 23;
  localparam int PAD_PG7 = 24;
  localparam int PAD_PI0 = 25;
  localparam int PAD_PI1 = 26;
  localparam int PAD_PI2 = 27;
  localparam int PAD_PI3 = 28;
  localparam int PAD_LSE = 29;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } prm_bus_req_t;

  // Signals that the peripherals drive toward the pads and the DMA.
  typedef struct packed {
    logic sp1_mosi;
    logic sp1_sck;
    logic sp1_nss;
    logic sp2_mosi;
    logic sp2_sck;
    logic sp2_nss;
    logic uart_tx;
    logic uart_ck;
    logic tim_dma_req;
    logic adc_dma_req;
  } prm_per_out_t;

  // Signals that the block returns to the peripherals.
  typedef struct packed {
    logic sp1_miso;
    logic sp2_miso;
    logic uart_rx;
    logic tim2_trig;
    logic tim3_trig;
    logic tim2_brk;
    logic tim3_brk;
    logic adc_trig;
    logic tim_dma_ack;
    logic adc_dma_ack;
  } prm_per_in_t;

endpackage

`default_nettype wire

// ===== hw/prm_sync.sv
`default_nettype none

// Two-stage synchroniser for pad inputs.
module prm_sync #(
  parameter int W = 32
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_nxt;

  always_comb begin
    meta_nxt = d;
    q_nxt    = meta_r;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= meta_nxt;
      q      <= q_nxt;
    end
  end

endmodule

`default_nettype wire

// ===== hw/prm_dma_route.sv
`default_nettype none

// Steers two request/acknowledge pairs onto four DMA channels.
module prm_dma_route
  import prm_pkg::*;
(
  input  wire logic [SEL_W-1:0] tim_sel,
  input  wire logic [SEL_W-1:0] adc_sel,
  input  wire logic             tim_req,
  input  wire logic             adc_req,
  input  wire logic [N_CH-1:0]  ch_ack,
  output var  logic [N_CH-1:0]  ch_req,
  output var  logic             tim_ack,
  output var  logic             adc_ack
);

  function automatic logic [N_CH-1:0] one_hot(input logic [SEL_W-1:0] sel);
    logic [N_CH-1:0] oh;
    oh      = '0;
    oh[sel] = 1'b1;
    return oh;
  endfunction

  logic [N_CH-1:0] tim_oh;
  logic [N_CH-1:0] adc_oh;

  assign tim_oh  = one_hot(tim_sel);
  assign adc_oh  = one_hot(adc_sel);
  assign tim_ack = |(ch_ack & tim_oh);
  assign adc_ack = |(ch_ack & adc_oh);

  // Two pairs on one channel share it; their requests are merged.
  for (genvar i = 0; i < N_CH; i++) begin : g_ch
    assign ch_req[i] = (tim_oh[i] & tim_req) | (adc_oh[i] & adc_req);
  end

endmodule

`default_nettype wire

// ===== hw/prm_remap_ctrl.sv
`default_nettype none

// Summary of operation
// - Pin-alternate bit clear puts port one MISO/MOSI/SCK/NSS on PB7/PB6/PB5/PB4.
// - Pin-alternate bit set puts port one MISO/MOSI/SCK/NSS on PA2/PA3/PC6/PC5.
// - Bit 6 puts the serial clock on PC4 when clear, PA0 when set.
// - Bits 5:4 place TX/RX on PC3/PC2, PA2/PA3, PC5/PC6; code 11 reserved.
// - Bits 3:2 put the timer DMA pair on channel 0 to 3.
// - Bits 1:0 put the converter DMA pair on channel 0 to 3.
// - Register one at offset 0x01 resets to 0x0c.
// - Register two at offset 0x02 resets to zero, eight read/write bits.
// - Register two bit 1 takes timer two trigger from PB3 or PA4.
// - Register two bit 2 takes timer three trigger from PD1 or PA5.
module prm_remap_ctrl
  import prm_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  input  wire prm_pkg::prm_bus_req_t         bus,
  output var  logic [prm_pkg::DATA_W-1:0]    rdata,
  input  wire prm_pkg::prm_per_out_t         per_out,
  output var  prm_pkg::prm_per_in_t          per_in,
  output var  logic [prm_pkg::N_CH-1:0]      dma_req,
  input  wire logic [prm_pkg::N_CH-1:0]      dma_ack,
  input  wire logic [prm_pkg::N_PAD-1:0]     pad_in,
  output var  logic [prm_pkg::N_PAD-1:0]     pad_out,
  output var  logic [prm_pkg::N_PAD-1:0]     pad_oe_b
);

  import prm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  logic [DATA_W-1:0] rmp1_r;
  logic [DATA_W-1:0] rmp1_nxt;
  logic [DATA_W-1:0] rmp2_r;
  logic [DATA_W-1:0] rmp2_nxt;
  logic [DATA_W-1:0] rdata_nxt;
  logic [N_PAD-1:0]  pad_out_nxt;
  logic [N_PAD-1:0]  pad_oe_b_nxt;
  logic [N_CH-1:0]   dma_req_nxt;
  prm_per_in_t       per_in_nxt;
  logic [N_PAD-1:0]  pin_s;
  logic [N_CH-1:0]   rt_req;
  logic              rt_tim_ack;
  logic              rt_adc_ack;
  prm_utr_t          utr_sel;

  assign utr_sel = prm_utr_t'(rmp1_r[UTR_LO+:SEL_W]);

  ////////////////////////////////////////////////////////////////////////////
  // Pad inputs cross into the clock domain here.
  prm_sync #(
    .W (N_PAD)
  ) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d     (pad_in),
    .q     (pin_s)
  );

  prm_dma_route u_dma (
    .tim_sel (rmp1_r[TDMA_LO+:SEL_W]),
    .adc_sel (rmp1_r[ADMA_LO+:SEL_W]),
    .tim_req (per_out.tim_dma_req),
    .adc_req (per_out.adc_dma_req),
    .ch_ack  (dma_ack),
    .ch_req  (rt_req),
    .tim_ack (rt_tim_ack),
    .adc_ack (rt_adc_ack)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register file.
  always_comb begin
    rmp1_nxt  = rmp1_r;
    rmp2_nxt  = rmp2_r;
    rdata_nxt = RD_UNMAPPED;
    if (bus.wr && bus.addr == RMP1_OFS) begin
      rmp1_nxt = bus.wdata;
    end
    if (bus.wr && bus.addr == RMP2_OFS) begin
      rmp2_nxt = bus.wdata;
    end
    if (bus.rd && bus.addr == RMP1_OFS) begin
      rdata_nxt = rmp1_r;
    end else if (bus.rd && bus.addr == RMP2_OFS) begin
      rdata_nxt = rmp2_r;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rmp1_r <= RMP1_RST;
      rmp2_r <= RMP2_RST;
      rdata  <= RD_UNMAPPED;
    end else begin
      rmp1_r <= rmp1_nxt;
      rmp2_r <= rmp2_nxt;
      rdata  <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Routing from the stored bits; every result is registered once more.
  // routing from stored bits
  always_comb begin
    pad_out_nxt  = '0;
    pad_oe_b_nxt = '1;
    per_in_nxt   = '0;
    unique case (utr_sel)
      UTR_PORTC: begin
        pad_out_nxt[PAD_PC3]  = per_out.uart_tx;
        pad_oe_b_nxt[PAD_PC3] = 1'b0;
        per_in_nxt.uart_rx    = pin_s[PAD_PC2];
      end
      UTR_PORTA: begin
        pad_out_nxt[PAD_PA2]  = per_out.uart_tx;
        pad_oe_b_nxt[PAD_PA2] = 1'b0;
        per_in_nxt.uart_rx    = pin_s[PAD_PA3];
      end
      UTR_PORTC_HI: begin
        pad_out_nxt[PAD_PC5]  = per_out.uart_tx;
        pad_oe_b_nxt[PAD_PC5] = 1'b0;
        per_in_nxt.uart_rx    = pin_s[PAD_PC6];
      end
      UTR_RSVD: begin
        // No transmit pad is driven; the receiver sees an idle line.
        per_in_nxt.uart_rx = 1'b1;
      end
    endcase
    if (rmp1_r[UCK_ALT_BIT]) begin
      pad_out_nxt[PAD_PA0]  = per_out.uart_ck;
      pad_oe_b_nxt[PAD_PA0] = 1'b0;
    end else begin
      pad_out_nxt[PAD_PC4]  = per_out.uart_ck;
      pad_oe_b_nxt[PAD_PC4] = 1'b0;
    end
    // Serial port one is placed after the transmit/receive and clock pads so it wins a shared pad.
    if (rmp1_r[SP1_ALT_BIT]) begin
      per_in_nxt.sp1_miso   = pin_s[PAD_PA2];
      pad_out_nxt[PAD_PA3]  = per_out.sp1_mosi;
      pad_oe_b_nxt[PAD_PA3] = 1'b0;
      pad_out_nxt[PAD_PC6]  = per_out.sp1_sck;
      pad_oe_b_nxt[PAD_PC6] = 1'b0;
      pad_out_nxt[PAD_PC5]  = per_out.sp1_nss;
      pad_oe_b_nxt[PAD_PC5] = 1'b0;
    end else begin
      per_in_nxt.sp1_miso   = pin_s[PAD_PB7];
      pad_out_nxt[PAD_PB6]  = per_out.sp1_mosi;
      pad_oe_b_nxt[PAD_PB6] = 1'b0;
      pad_out_nxt[PAD_PB5]  = per_out.sp1_sck;
      pad_oe_b_nxt[PAD_PB5] = 1'b0;
      pad_out_nxt[PAD_PB4]  = per_out.sp1_nss;
      pad_oe_b_nxt[PAD_PB4] = 1'b0;
    end
    if (rmp2_r[SP2_ALT_BIT]) begin
      per_in_nxt.sp2_miso   = pin_s[PAD_PI3];
      pad_out_nxt[PAD_PI2]  = per_out.sp2_mosi;
      pad_oe_b_nxt[PAD_PI2] = 1'b0;
      pad_out_nxt[PAD_PI1]  = per_out.sp2_sck;
      pad_oe_b_nxt[PAD_PI1] = 1'b0;
      pad_out_nxt[PAD_PI0]  = per_out.sp2_nss;
      pad_oe_b_nxt[PAD_PI0] = 1'b0;
    end else begin
      per_in_nxt.sp2_miso   = pin_s[PAD_PG7];
      pad_out_nxt[PAD_PG6]  = per_out.sp2_mosi;
      pad_oe_b_nxt[PAD_PG6] = 1'b0;
      pad_out_nxt[PAD_PG5]  = per_out.sp2_sck;
      pad_oe_b_nxt[PAD_PG5] = 1'b0;
      pad_out_nxt[PAD_PG4]  = per_out.sp2_nss;
      pad_oe_b_nxt[PAD_PG4] = 1'b0;
    end
    if (rmp2_r[T2_LSE_BIT]) begin
      per_in_nxt.tim2_trig = pin_s[PAD_LSE];
    end else begin
      per_in_nxt.tim2_trig = rmp2_r[T2_ALT_BIT] ? pin_s[PAD_PA4] : pin_s[PAD_PB3];
    end
    if (rmp2_r[T3_LSE_BIT]) begin
      per_in_nxt.tim3_trig = pin_s[PAD_LSE];
    end else if (rmp2_r[T3_FAR_BIT]) begin
      per_in_nxt.tim3_trig = pin_s[PAD_PG3];
    end else begin
      per_in_nxt.tim3_trig = rmp2_r[T3_ALT_BIT] ? pin_s[PAD_PA5] : pin_s[PAD_PD1];
    end
    per_in_nxt.tim2_brk = rmp2_r[BRK_ALT_BIT] ? pin_s[PAD_PG0] : pin_s[PAD_PA4];
    per_in_nxt.tim3_brk = rmp2_r[BRK_ALT_BIT] ? pin_s[PAD_PG1] : pin_s[PAD_PA5];
    per_in_nxt.adc_trig = rmp2_r[ADCT_ALT_BIT] ? pin_s[PAD_PD0] : pin_s[PAD_PA6];
    per_in_nxt.tim_dma_ack = rt_tim_ack;
    per_in_nxt.adc_dma_ack = rt_adc_ack;
    dma_req_nxt            = rt_req;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pad_out  <= '0;
      pad_oe_b <= '1;
      per_in   <= '0;
      dma_req  <= '0;
    end else begin
      pad_out  <= pad_out_nxt;
      pad_oe_b <= pad_oe_b_nxt;
      per_in   <= per_in_nxt;
      dma_req  <= dma_req_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  logic first_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      first_r <= 1'b1;
    end else begin
      first_r <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_reset_values: assert property (
    first_r |-> rmp1_r == RMP1_RST && rmp2_r == RMP2_RST
  ) else $error("remap registers left reset with wrong values");

  a_reg_two_rw: assert property (
    bus.wr && bus.addr == RMP2_OFS ##1 bus.rd && bus.addr == RMP2_OFS
      |=> rdata == $past(bus.wdata, 2)
  ) else $error("register two did not read back its write");

  a_port_one_default: assert property (
    !rmp1_r[SP1_ALT_BIT] |=> !pad_oe_b[PAD_PB5] && pad_oe_b[PAD_PC6]
      && pad_out[PAD_PB6] == $past(per_out.sp1_mosi)
  ) else $error("port one default placement wrong");

  a_port_one_alt: assert property (
    rmp1_r[SP1_ALT_BIT] |=> !pad_oe_b[PAD_PC6] && pad_oe_b[PAD_PB5]
      && pad_out[PAD_PC5] == $past(per_out.sp1_nss)
      && per_in.sp1_miso == $past(pin_s[PAD_PA2])
  ) else $error("port one alternate placement wrong");

  a_clock_pin: assert property (
    rmp1_r[UCK_ALT_BIT] |=> pad_out[PAD_PA0] == $past(per_out.uart_ck)
      && pad_oe_b[PAD_PC4]
  ) else $error("serial clock not on its alternate pad");

  a_txrx_place: assert property (
    utr_sel == UTR_PORTA |=> pad_out[PAD_PA2] == $past(per_out.uart_tx)
      && per_in.uart_rx == $past(pin_s[PAD_PA3])
  ) else $error("transmit and receive not on port A pads");

  a_timer_dma: assert property (
    per_out.tim_dma_req && !per_out.adc_dma_req
      |=> dma_req == N_CH'(1) << $past(rmp1_r[TDMA_LO+:SEL_W])
  ) else $error("timer DMA request on wrong channel");

  a_adc_dma_ack: assert property (
    ##1 per_in.adc_dma_ack == $past(dma_ack[rmp1_r[ADMA_LO+:SEL_W]])
  ) else $error("converter DMA acknowledge from wrong channel");

  a_timer_two_trig: assert property (
    !rmp2_r[T2_LSE_BIT] && rmp2_r[T2_ALT_BIT]
      |=> per_in.tim2_trig == $past(pin_s[PAD_PA4])
  ) else $error("timer two trigger not taken from its alternate pad");

  a_timer_three_trig: assert property (
    rmp2_r[T3_LSE_BIT+:1] == 1'b0 && !rmp2_r[T3_FAR_BIT] && !rmp2_r[T3_ALT_BIT]
      |=> per_in.tim3_trig == $past(pin_s[PAD_PD1])
  ) else $error("timer three trigger not taken from its default pad");

  a_route_latency: assert property (
    bus.wr && bus.addr == RMP1_OFS && bus.wdata[SP1_ALT_BIT]
      |=> ##1 !pad_oe_b[PAD_PC6]
  ) else $error("new routing not seen two edges after the write");

  c_port_one_alt: cover property (
    bus.wr && bus.addr == RMP1_OFS && bus.wdata[SP1_ALT_BIT]
  );
  c_txrx_reserved: cover property (utr_sel == UTR_RSVD);
  c_shared_channel: cover property (
    rmp1_r[TDMA_LO+:SEL_W] == rmp1_r[ADMA_LO+:SEL_W]
      && per_out.tim_dma_req && per_out.adc_dma_req
  );
  c_lse_trigger: cover property (rmp2_r[T2_LSE_BIT] && rmp2_r[T3_LSE_BIT]);

endmodule

`default_nettype wire

// ===== bench/testbench.sv
`default_nettype none

module testbench
  import prm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                 clk;
  logic                 rst_b;
  prm_bus_req_t         bus;
  logic [DATA_W-1:0]    rdata;
  prm_per_out_t         per_out;
  prm_per_in_t          per_in;
  logic [N_CH-1:0]      dma_req;
  logic [N_CH-1:0]      dma_ack;
  logic [N_PAD-1:0]     pad_in;
  logic [N_PAD-1:0]     pad_out;
  logic [N_PAD-1:0]     pad_oe_b;
  int                   fails;
  int                   n_compared;

  prm_remap_ctrl DUT (
    .clk      (clk),
    .rst_b    (rst_b),
    .bus      (bus),
    .rdata    (rdata),
    .per_out  (per_out),
    .per_in   (per_in),
    .dma_req  (dma_req),
    .dma_ack  (dma_ack),
    .pad_in   (pad_in),
    .pad_out  (pad_out),
    .pad_oe_b (pad_oe_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic cmp_bit(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    cmp_word({24'h0, rdata}, {24'h0, exp}, "read data");
  endtask

  // A write followed at once by a read of the same register, with no idle cycle.
  task automatic bus_wr_rd(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    cmp_word({24'h0, rdata}, {24'h0, d}, "back to back read data");
  endtask

  // The new routing shows one edge after the write has been taken.
  task automatic wr_settle(input logic [7:0] a, input logic [7:0] d);
    bus_wr(a, d);
    @(posedge clk);
    #1;
  endtask

  task automatic chk_drv(input int idx, input logic v);
    cmp_bit(pad_oe_b[idx], 1'b0, "pad enable");
    cmp_bit(pad_out[idx], v, "pad level");
  endtask

  // Only the chosen pad differs from all others, so a wrong source shows.
  task automatic pin_in(input int idx, input logic v);
    @(posedge clk);
    pad_in <= v ? (32'h1 << idx) : ~(32'h1 << idx);
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic sp1_chk(input int mo, input int sc, input int ns, input int mi);
    for (int p = 0; p < 3; p++) begin
      @(posedge clk);
      per_out.sp1_mosi <= (p == 0);
      per_out.sp1_sck  <= (p == 1);
      per_out.sp1_nss  <= (p == 2);
      @(posedge clk);
      #1;
      chk_drv(mo, p == 0);
      chk_drv(sc, p == 1);
      chk_drv(ns, p == 2);
    end
    for (int v = 1; v >= 0; v--) begin
      pin_in(mi, 1'(v));
      cmp_bit(per_in.sp1_miso, 1'(v), "port one input");
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic sc_reset_regs();
    bus_rd(RMP1_OFS, 8'h0c);
    @(posedge clk);
    #1;
    cmp_word({24'h0, rdata}, 32'h0, "idle read data");
    bus_rd(RMP2_OFS, 8'h00);
    bus_rd(8'h03, 8'h00);
  endtask

  task automatic sc_sp1();
    sp1_chk(PAD_PB6, PAD_PB5, PAD_PB4, PAD_PB7);
    bus_wr(RMP1_OFS, 8'h8c);
    #1;
    cmp_bit(pad_oe_b[PAD_PB6], 1'b0, "old routing held");
    @(posedge clk);
    #1;
    cmp_bit(pad_oe_b[PAD_PB6], 1'b1, "old pad released");
    sp1_chk(PAD_PA3, PAD_PC6, PAD_PC5, PAD_PA2);
    wr_settle(RMP1_OFS, 8'h0c);
  endtask

  task automatic sc_uck();
    @(posedge clk);
    per_out.uart_ck <= 1'b1;
    @(posedge clk);
    #1;
    chk_drv(PAD_PC4, 1'b1);
    cmp_bit(pad_oe_b[PAD_PA0], 1'b1, "clock alt pad idle");
    wr_settle(RMP1_OFS, 8'h4c);
    chk_drv(PAD_PA0, 1'b1);
    cmp_bit(pad_oe_b[PAD_PC4], 1'b1, "clock pad released");
    wr_settle(RMP1_OFS, 8'h0c);
  endtask

  task automatic sc_utr();
    int tx[3];
    int rx[3];
    tx = '{PAD_PC3, PAD_PA2, PAD_PC5};
    rx = '{PAD_PC2, PAD_PA3, PAD_PC6};
    @(posedge clk);
    per_out.uart_tx <= 1'b1;
    for (int c = 0; c < 3; c++) begin
      wr_settle(RMP1_OFS, 8'(c * 16 + 12));
      for (int k = 0; k < 3; k++) begin
        cmp_bit(pad_oe_b[tx[k]], 1'(k != c), "transmit pad enable");
      end
      chk_drv(tx[c], 1'b1);
      for (int v = 1; v >= 0; v--) begin
        pin_in(rx[c], 1'(v));
        cmp_bit(per_in.uart_rx, 1'(v), "receive input");
      end
    end
    wr_settle(RMP1_OFS, 8'h3c);
    bus_rd(RMP1_OFS, 8'h3c);
    for (int k = 0; k < 3; k++) begin
      cmp_bit(pad_oe_b[tx[k]], 1'b1, "reserved code drives nothing");
    end
    pin_in(31, 1'b1);
    cmp_bit(per_in.uart_rx, 1'b1, "reserved code receive idle");
    wr_settle(RMP1_OFS, 8'h0c);
  endtask

  task automatic sc_dma();
    for (int c = 0; c < 4; c++) begin
      wr_settle(RMP1_OFS, 8'(c * 4 + 3 - c));
      @(posedge clk);
      per_out.tim_dma_req <= 1'b1;
      per_out.adc_dma_req <= 1'b0;
      dma_ack             <= 4'(1 << c);
      @(posedge clk);
      #1;
      cmp_word(32'(dma_req), 32'(1 << c), "timer request channel");
      cmp_bit(per_in.tim_dma_ack, 1'b1, "timer ack");
      cmp_bit(per_in.adc_dma_ack, 1'b0, "converter ack quiet");
      @(posedge clk);
      per_out.tim_dma_req <= 1'b0;
      per_out.adc_dma_req <= 1'b1;
      dma_ack             <= 4'(1 << (3 - c));
      @(posedge clk);
      #1;
      cmp_word(32'(dma_req), 32'(1 << (3 - c)), "converter request channel");
      cmp_bit(per_in.adc_dma_ack, 1'b1, "converter ack");
      cmp_bit(per_in.tim_dma_ack, 1'b0, "timer ack quiet");
    end
    @(posedge clk);
    per_out.adc_dma_req <= 1'b0;
    dma_ack             <= 4'h0;
    wr_settle(RMP1_OFS, 8'h0c);
  endtask

  task automatic trig_chk(input logic [7:0] val, input int src, input logic t3);
    wr_settle(RMP2_OFS, val);
    for (int v = 1; v >= 0; v--) begin
      pin_in(src, 1'(v));
      cmp_bit(t3 ? per_in.tim3_trig : per_in.tim2_trig, 1'(v), "trigger source");
    end
  endtask

  task automatic sc_reg2();
    trig_chk(8'h00, PAD_PB3, 1'b0);
    trig_chk(8'h02, PAD_PA4, 1'b0);
    trig_chk(8'h00, PAD_PD1, 1'b1);
    trig_chk(8'h04, PAD_PA5, 1'b1);
    bus_wr(RMP2_OFS, 8'ha5);
    bus_wr(8'h03, 8'h5a);
    bus_rd(RMP2_OFS, 8'ha5);
    bus_rd(RMP1_OFS, 8'h0c);
    bus_wr_rd(RMP2_OFS, 8'h5a);
  endtask

  // Port two, break inputs, converter trigger and the other trigger sources.
  task automatic sc_reg2_rest();
    @(posedge clk);
    per_out.sp2_mosi <= 1'b1;
    per_out.sp2_sck  <= 1'b0;
    per_out.sp2_nss  <= 1'b1;
    wr_settle(RMP2_OFS, 8'h00);
    chk_drv(PAD_PG6, 1'b1);
    chk_drv(PAD_PG5, 1'b0);
    chk_drv(PAD_PG4, 1'b1);
    cmp_bit(pad_oe_b[PAD_PI2], 1'b1, "port two alt pad idle");
    pin_in(PAD_PG7, 1'b1);
    cmp_bit(per_in.sp2_miso, 1'b1, "port two input");
    pin_in(PAD_PA4, 1'b1);
    cmp_bit(per_in.tim2_brk, 1'b1, "break two input");
    pin_in(PAD_PA5, 1'b1);
    cmp_bit(per_in.tim3_brk, 1'b1, "break three input");
    pin_in(PAD_PA6, 1'b1);
    cmp_bit(per_in.adc_trig, 1'b1, "converter trigger");
    wr_settle(RMP2_OFS, 8'ha1);
    chk_drv(PAD_PI2, 1'b1);
    chk_drv(PAD_PI1, 1'b0);
    chk_drv(PAD_PI0, 1'b1);
    cmp_bit(pad_oe_b[PAD_PG6], 1'b1, "port two default pad released");
    pin_in(PAD_PI3, 1'b1);
    cmp_bit(per_in.sp2_miso, 1'b1, "port two alt input");
    pin_in(PAD_PG0, 1'b1);
    cmp_bit(per_in.tim2_brk, 1'b1, "break two alt input");
    pin_in(PAD_PG1, 1'b1);
    cmp_bit(per_in.tim3_brk, 1'b1, "break three alt input");
    pin_in(PAD_PD0, 1'b1);
    cmp_bit(per_in.adc_trig, 1'b1, "converter trigger alt");
    wr_settle(RMP2_OFS, 8'h18);
    pin_in(PAD_LSE, 1'b1);
    cmp_bit(per_in.tim2_trig, 1'b1, "timer two oscillator trigger");
    cmp_bit(per_in.tim3_trig, 1'b1, "timer three oscillator trigger");
    wr_settle(RMP2_OFS, 8'h40);
    pin_in(PAD_PG3, 1'b1);
    cmp_bit(per_in.tim3_trig, 1'b1, "timer three far trigger");
    @(posedge clk);
    per_out.sp2_mosi <= 1'b0;
    per_out.sp2_nss  <= 1'b0;
  endtask

  task automatic sc_rst();
    bus_wr(RMP1_OFS, 8'hef);
    @(posedge clk);
    rst_b <= 1'b0;
    @(posedge clk);
    #1;
    cmp_word(pad_oe_b, 32'hffffffff, "enables in reset");
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    bus_rd(RMP1_OFS, 8'h0c);
    bus_rd(RMP2_OFS, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b      = 1'b0;
    bus        = '0;
    per_out    = '0;
    dma_ack    = '0;
    pad_in     = '0;
    fails      = 0;
    n_compared = 0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    sc_reset_regs();
    sc_sp1();
    sc_uck();
    sc_utr();
    sc_dma();
    sc_reg2();
    sc_reg2_rest();
    sc_rst();
    tally_and_finish();
  end

  // A hung run is cut short and counted as a mismatch.
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    $display("ERROR at %0t: run did not finish in time", $time);
    tally_and_finish();
  end

endmodule

`default_nettype wire
